// ===== verilog/srw_pkg.sv
// Package: constants and types for the serial register write link
// Operation
// - Write is 12-bit address plus 28-bit data
// - Address and data shifted LSB first
// - Single write is exactly forty bits
// - Host pads unused data bits with zeros
// - Short data word is discarded, register unchanged
// - Continuous mode auto-increments the address
// - Auto-increment may start at any address
// - Host holds load strobe low through burst
// - Fixed registers decode at 0x00 to 0x72
// - Pattern groups start 0x800, at most 32
// - Field base is 0x800 plus sixteen times count
// - Host keeps pattern and field run unbroken
// - Host never writes undefined low addresses
// - Immediate registers update on top data bit
// - Sync registers apply at vertical sync fall
// - Update line delays sync type, not fields
// - Pattern registers apply at next used sample
package srw_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 28;
  localparam int FRAME_W = 40;
  localparam int CNT_W = 6;
  localparam logic [11:0] FIXED_LAST = 12'h072;
  localparam logic [11:0] HPAT_BASE = 12'h800;
  localparam logic [11:0] ADDR_UPDATE_LINE = 12'h017;
  localparam logic [11:0] ADDR_HPAT_COUNT = 12'h028;
  localparam logic [27:0] HPAT_MAX = 28'h0000020;
  localparam int GROUP_SHIFT = 4;
  localparam int GROUP_W = 5;
  localparam logic [27:0] UPDATE_LINE_RST = 28'h0000000;
  localparam logic [27:0] HPAT_COUNT_RST = 28'h0000000;
  // Host clock divider: 160 ns link period from 20 ns clock
  localparam int LINK_PERIOD_NS = 160;
  localparam int CLK_PERIOD_NS = 20;
  localparam int HALF_DIV = LINK_PERIOD_NS / CLK_PERIOD_NS / 2;
  localparam logic [3:0] HALF_DIV_M1 = 4'(HALF_DIV - 1);

  typedef enum logic [1:0] {
    UPD_IMMEDIATE = 2'h0,
    UPD_VSYNC = 2'h1,
    UPD_SAMPLE = 2'h2,
    UPD_NONE = 2'h3
  } srw_upd_e;
endpackage

// ===== verilog/srw_link_if.sv
// Interface: three-wire serial write link between host and device
`timescale 1ns/10ps
interface srw_link_if;
  logic serial_clock;
  logic serial_data;
  logic serial_load_strobe;

  modport host (
    output serial_clock,
    output serial_data,
    output serial_load_strobe
  );
  modport device (
    input serial_clock,
    input serial_data,
    input serial_load_strobe
  );
endinterface

// ===== verilog/srw_device.sv
// Device end: serial receiver, address map and update timing
`timescale 1ns/10ps
module srw_device (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // Serial link
  srw_link_if.device link,
  // Timing events from the timing core
  input wire logic vertical_sync_in,
  input wire logic horizontal_sync_in,
  input wire logic pixel_sample_point_in,
  input wire logic [4:0] pattern_in_use_in,
  // Committed register write
  output logic wr_valid_out,
  output logic [srw_pkg::ADDR_W-1:0] wr_addr_out,
  output logic [srw_pkg::DATA_W-1:0] wr_data_out,
  output srw_pkg::srw_upd_e wr_type_out,
  // Applied register contents
  output logic [srw_pkg::DATA_W-1:0] update_line_out,
  output logic [srw_pkg::DATA_W-1:0] hpat_count_out,
  output logic [srw_pkg::ADDR_W-1:0] field_base_out,
  // Update moments and address error flag
  output logic vsync_apply_out,
  output logic field_apply_out,
  output logic pattern_apply_out,
  output logic [4:0] pattern_apply_grp_out,
  output logic addr_error_out
);
  import srw_pkg::*;

  typedef struct packed {
    logic [2:0] sck_s;
    logic [2:0] sl_s;
    logic [2:0] sd_s;
    logic [2:0] vd_s;
    logic [2:0] hd_s;
    logic sck_q;
    logic sl_q;
    logic vd_q;
    logic hd_q;
    logic [CNT_W-1:0] bits;
    logic addr_done;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] shreg;
    logic wr_valid;
    logic [ADDR_W-1:0] wr_addr;
    logic [DATA_W-1:0] wr_data;
    srw_upd_e wr_type;
    logic addr_error;
    logic [DATA_W-1:0] upd_line;
    logic [DATA_W-1:0] upd_line_pend;
    logic upd_line_dirty;
    logic [DATA_W-1:0] hpat_cnt;
    logic [DATA_W-1:0] hpat_pend;
    logic hpat_dirty;
    logic vs_pending;
    logic fld_pending;
    logic [DATA_W-1:0] line_cnt;
    logic vs_apply;
    logic fld_apply;
    logic [31:0] pat_pend;
    logic pat_apply;
    logic [4:0] pat_grp;
  } srw_dev_s;

  srw_dev_s st;
  srw_dev_s next_st;

  function automatic srw_upd_e classify(input logic [ADDR_W-1:0] a,
                                       input logic [DATA_W-1:0] cnt);
    logic [ADDR_W-1:0] fbase;
    fbase = HPAT_BASE + (ADDR_W'(cnt[GROUP_W:0]) << GROUP_SHIFT);
    classify = UPD_NONE;
    if (a <= FIXED_LAST) begin
      // Low area: 0x00 to 0x03, update line and count act at once, the rest at sync
      if (a == ADDR_UPDATE_LINE || a == ADDR_HPAT_COUNT || a < 12'h004)
        classify = UPD_IMMEDIATE;
      else
        classify = UPD_VSYNC;
    end else if (a >= HPAT_BASE && a < fbase) begin
      classify = UPD_SAMPLE;
    end else if (a >= fbase) begin
      classify = UPD_VSYNC;
    end
  endfunction

  always_comb begin
    logic sck_rise;
    logic sl_rise;
    logic vd_fall;
    logic hd_fall;
    logic [DATA_W-1:0] word;
    logic [GROUP_W-1:0] grp;
    next_st = st;
    word = '0;
    grp = '0;
    sck_rise = 1'b0;
    sl_rise = 1'b0;
    vd_fall = 1'b0;
    hd_fall = 1'b0;
    next_st.sck_s = {st.sck_s[1:0], link.serial_clock};
    next_st.sl_s = {st.sl_s[1:0], link.serial_load_strobe};
    next_st.sd_s = {st.sd_s[1:0], link.serial_data};
    next_st.vd_s = {st.vd_s[1:0], vertical_sync_in};
    next_st.hd_s = {st.hd_s[1:0], horizontal_sync_in};
    // Change counts once stages two and three agree
    if (st.sck_s[1] == st.sck_s[2]) next_st.sck_q = st.sck_s[2];
    if (st.sl_s[1] == st.sl_s[2]) next_st.sl_q = st.sl_s[2];
    if (st.vd_s[1] == st.vd_s[2]) next_st.vd_q = st.vd_s[2];
    if (st.hd_s[1] == st.hd_s[2]) next_st.hd_q = st.hd_s[2];
    sck_rise = next_st.sck_q && !st.sck_q;
    sl_rise = next_st.sl_q && !st.sl_q;
    vd_fall = !next_st.vd_q && st.vd_q;
    hd_fall = !next_st.hd_q && st.hd_q;
    next_st.wr_valid = 1'b0;
    next_st.vs_apply = 1'b0;
    next_st.fld_apply = 1'b0;
    next_st.pat_apply = 1'b0;

    if (sl_rise || st.sl_q) begin
      // Partial data word is dropped with the frame
      next_st.bits = '0;
      next_st.addr_done = 1'b0;
    end else if (sck_rise) begin
      // LSB first: shift in from the top
      word = {st.sd_s[2], st.shreg[DATA_W-1:1]};
      next_st.shreg = word;
      next_st.bits = st.bits + 1'b1;
      if (!st.addr_done && st.bits == CNT_W'(ADDR_W - 1)) begin
        next_st.addr = word[DATA_W-1 -: ADDR_W];
        next_st.addr_done = 1'b1;
        next_st.bits = '0;
      end else if (st.addr_done && st.bits == CNT_W'(DATA_W - 1)) begin
        // Word complete on top data bit; burst moves on
        next_st.bits = '0;
        next_st.addr = st.addr + 1'b1;
        next_st.wr_valid = 1'b1;
        next_st.wr_addr = st.addr;
        next_st.wr_data = word;
        next_st.wr_type = classify(st.addr, st.hpat_cnt);
        next_st.addr_error = (next_st.wr_type == UPD_NONE);
        if (st.addr == ADDR_UPDATE_LINE)
          next_st.upd_line = word;
        if (st.addr == ADDR_HPAT_COUNT)
          next_st.hpat_cnt = (word > HPAT_MAX) ? HPAT_MAX : word;
        case (next_st.wr_type)
          UPD_VSYNC: begin
            if (st.addr >= HPAT_BASE) next_st.fld_pending = 1'b1;
            else next_st.vs_pending = 1'b1;
          end
          UPD_SAMPLE: begin
            grp = st.addr[GROUP_SHIFT +: GROUP_W];
            next_st.pat_pend[grp] = 1'b1;
          end
          default: begin
          end
        endcase
      end
    end

    // Line counter restarts at each field
    if (vd_fall) next_st.line_cnt = '0;
    else if (hd_fall) next_st.line_cnt = st.line_cnt + 1'b1;
    // Field registers apply at the sync edge regardless of update line
    if (vd_fall && st.fld_pending) begin
      next_st.fld_apply = 1'b1;
      // A field write landing on the same edge stays pending
      next_st.fld_pending = next_st.wr_valid &&
                            next_st.wr_type == UPD_VSYNC &&
                            st.addr >= HPAT_BASE;
    end
    // Low sync registers wait for the chosen line
    if (st.vs_pending && next_st.line_cnt == st.upd_line &&
        (st.upd_line == '0 ? vd_fall : hd_fall)) begin
      next_st.vs_apply = 1'b1;
      next_st.vs_pending = next_st.wr_valid &&
                           next_st.wr_type == UPD_VSYNC &&
                           st.addr < HPAT_BASE;
    end
    if (pixel_sample_point_in && st.pat_pend[pattern_in_use_in]) begin
      next_st.pat_apply = 1'b1;
      next_st.pat_grp = pattern_in_use_in;
      if (!(next_st.wr_valid && next_st.wr_type == UPD_SAMPLE &&
            grp == pattern_in_use_in))
        next_st.pat_pend[pattern_in_use_in] = 1'b0;
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      st <= '0;
      st.sl_s <= 3'h7;
      st.sl_q <= 1'b1;
      st.wr_type <= UPD_NONE;
      st.upd_line <= UPDATE_LINE_RST;
      st.hpat_cnt <= HPAT_COUNT_RST;
    end else begin
      st <= next_st;
    end
  end

  assign wr_valid_out = st.wr_valid;
  assign wr_addr_out = st.wr_addr;
  assign wr_data_out = st.wr_data;
  assign wr_type_out = st.wr_type;
  assign update_line_out = st.upd_line;
  assign hpat_count_out = st.hpat_cnt;
  assign field_base_out =
    HPAT_BASE + (ADDR_W'(st.hpat_cnt[GROUP_W:0]) << GROUP_SHIFT);
  assign vsync_apply_out = st.vs_apply;
  assign field_apply_out = st.fld_apply;
  assign pattern_apply_out = st.pat_apply;
  assign pattern_apply_grp_out = st.pat_grp;
  assign addr_error_out = st.addr_error;
endmodule

// ===== verilog/srw_host.sv
// Host end: drives forty-bit and burst writes over the serial link
`timescale 1ns/10ps
module srw_host (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // Command: start a burst of words at one address
  input wire logic start_in,
  input wire logic [srw_pkg::ADDR_W-1:0] addr_in,
  input wire logic [4:0] word_count_m1_in,
  // Word supply and busy flag
  input wire logic [srw_pkg::DATA_W-1:0] data_in,
  output logic data_take_out,
  output logic busy_out,
  // Serial link
  srw_link_if.host link
);
  import srw_pkg::*;

  typedef enum logic [2:0] {
    HS_IDLE = 3'b001,
    HS_SHIFT = 3'b010,
    HS_END = 3'b100
  } srw_hs_e;

  typedef struct packed {
    srw_hs_e state;
    logic [3:0] div;
    logic sck;
    logic sl;
    logic sd;
    logic [DATA_W-1:0] shreg;
    logic [CNT_W-1:0] bits;
    logic in_addr;
    logic [4:0] words_left;
    logic take;
  } srw_host_s;

  srw_host_s st;
  srw_host_s next_st;

  always_comb begin
    logic tick;
    next_st = st;
    next_st.take = 1'b0;
    tick = (st.div == HALF_DIV_M1);
    next_st.div = tick ? '0 : st.div + 1'b1;
    case (st.state)
      HS_IDLE: begin
        next_st.sck = 1'b0;
        next_st.sl = 1'b1;
        if (start_in) begin
          next_st.state = HS_SHIFT;
          next_st.sl = 1'b0;
          next_st.shreg = DATA_W'(addr_in);
          next_st.sd = addr_in[0];
          next_st.bits = '0;
          next_st.in_addr = 1'b1;
          next_st.words_left = word_count_m1_in;
          next_st.div = '0;
        end
      end
      HS_SHIFT: begin
        if (tick && !st.sck) begin
          next_st.sck = 1'b1; // Device samples here
        end else if (tick) begin
          next_st.sck = 1'b0;
          next_st.shreg = {1'b0, st.shreg[DATA_W-1:1]};
          next_st.sd = st.shreg[1];
          next_st.bits = st.bits + 1'b1;
          if (st.in_addr && st.bits == CNT_W'(ADDR_W - 1)) begin
            // All 28 bits always sent; caller pads high bits
            next_st.in_addr = 1'b0;
            next_st.bits = '0;
            next_st.shreg = data_in;
            next_st.sd = data_in[0];
            next_st.take = 1'b1;
          end else if (!st.in_addr &&
                       st.bits == CNT_W'(DATA_W - 1)) begin
            next_st.bits = '0;
            if (st.words_left == '0) begin
              next_st.state = HS_END;
            end else begin
              next_st.words_left = st.words_left - 1'b1;
              next_st.shreg = data_in;
              next_st.sd = data_in[0];
              next_st.take = 1'b1;
            end
          end
        end
      end
      HS_END: begin
        // Strobe rises only after the last word is in
        if (tick) begin
          next_st.sl = 1'b1;
          next_st.state = HS_IDLE;
        end
      end
      default: next_st.state = HS_IDLE;
    endcase
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      st <= '0;
      st.state <= HS_IDLE;
      st.sl <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign link.serial_clock = st.sck;
  assign link.serial_data = st.sd;
  assign link.serial_load_strobe = st.sl;
  assign data_take_out = st.take;
  assign busy_out = (st.state != HS_IDLE);
endmodule

// ===== verif/srw_link_asserts.sv
// Checker: wire-level rules of the serial write link
`timescale 1ns/10ps
module srw_link_asserts (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // Link wires
  input wire logic serial_clock_in,
  input wire logic serial_data_in,
  input wire logic serial_load_strobe_in
);
  logic prev_sck;
  logic [9:0] bits;

  default clocking @(posedge clock_in);
  endclocking
  default disable iff (rst_in);

  // Rising link edges seen in the open frame
  always_ff @(posedge clock_in) begin
    prev_sck <= serial_clock_in & ~rst_in;
    if (rst_in || serial_load_strobe_in) begin
      bits <= 10'h0;
    end else if (serial_clock_in && !prev_sck) begin
      bits <= bits + 10'h1;
    end
  end

  sequence half_high;
    serial_clock_in [*4];
  endsequence
  sequence half_low;
    !serial_clock_in [*4];
  endsequence

  a_idle_clock: assert property (
    serial_load_strobe_in |-> !serial_clock_in)
    else $error("link clock moved outside a frame");
  a_high_half: assert property (
    $rose(serial_clock_in) |-> half_high ##1 !serial_clock_in)
    else $error("link clock high half wrong");
  a_low_half: assert property (
    $fell(serial_clock_in) |-> half_low)
    else $error("link clock low half too short");
  a_frame_start: assert property (
    $fell(serial_load_strobe_in) |-> half_low ##1 serial_clock_in)
    else $error("first link edge misplaced");
  a_data_steady: assert property (
    serial_clock_in |-> $stable(serial_data_in))
    else $error("data moved while clock high");
  a_strobe_rise: assert property (
    $rose(serial_load_strobe_in) |-> !$past(serial_clock_in))
    else $error("strobe rose with clock high");
  a_frame_bits: assert property (
    $rose(serial_load_strobe_in) |->
      bits >= 10'h28 && (bits - 10'hc) % 10'h1c == 10'h0)
    else $error("frame not address plus whole words");
  a_burst_limit: assert property (
    !serial_load_strobe_in |-> bits <= 10'h38c)
    else $error("burst longer than allowed");
endmodule

// ===== verif/serial_register_write_and_update_bench.sv
// Bench: host and device joined over the serial link
`timescale 1ns/10ps
module serial_register_write_and_update_bench;
  import srw_pkg::*;
  typedef struct packed {
    logic [11:0] a;
    logic [27:0] d;
    srw_upd_e t;
  } srw_note_s;
  srw_note_s notes[$];
  logic clock_in = 0, rst_in = 1, start_in = 0;
  logic vsync = 1, hsync = 1, pix = 0;
  logic [11:0] addr_in = 0;
  logic [4:0] cnt_m1 = 0, grp = 0;
  logic [27:0] data_in = 0;
  logic take, busy, wv, wv2, va, fa, pa, aerr;
  logic [11:0] wa, wa2, fbase, got_a2;
  logic [27:0] wd, wd2, uline, hcnt, got_d2;
  logic [27:0] words [0:3];
  logic [4:0] pgrp;
  srw_upd_e wt;
  int n_fail = 0, n_tests = 0, cyc = 0, n_va = 0, n_fa = 0, n_pa = 0, n2 = 0;
  srw_link_if lnk();
  srw_link_if lnk2();

  srw_host u_srw_host (.clock_in, .rst_in, .start_in, .addr_in,
    .word_count_m1_in(cnt_m1), .data_in, .data_take_out(take),
    .busy_out(busy), .link(lnk.host));
  srw_device u_srw_device (.clock_in, .rst_in, .link(lnk.device),
    .vertical_sync_in(vsync), .horizontal_sync_in(hsync),
    .pixel_sample_point_in(pix), .pattern_in_use_in(grp),
    .wr_valid_out(wv), .wr_addr_out(wa), .wr_data_out(wd), .wr_type_out(wt),
    .update_line_out(uline), .hpat_count_out(hcnt), .field_base_out(fbase),
    .vsync_apply_out(va), .field_apply_out(fa), .pattern_apply_out(pa),
    .pattern_apply_grp_out(pgrp), .addr_error_out(aerr));
  // Second device faces a bench driver that can cut frames short
  srw_device u_srw_device_2 (.clock_in, .rst_in, .link(lnk2.device),
    .vertical_sync_in(vsync), .horizontal_sync_in(hsync),
    .pixel_sample_point_in(pix), .pattern_in_use_in(grp),
    .wr_valid_out(wv2), .wr_addr_out(wa2), .wr_data_out(wd2),
    .wr_type_out(), .update_line_out(), .hpat_count_out(),
    .field_base_out(), .vsync_apply_out(), .field_apply_out(),
    .pattern_apply_out(), .pattern_apply_grp_out(), .addr_error_out());
  srw_link_asserts u_srw_link_asserts (.clock_in, .rst_in,
    .serial_clock_in(lnk.serial_clock),
    .serial_data_in(lnk.serial_data),
    .serial_load_strobe_in(lnk.serial_load_strobe));

  initial forever #10 clock_in = ~clock_in;

  task tally_and_finish();
    if (n_fail == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task check(input logic ok, input string m);
    n_tests++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask

  task wait_cyc(input int n);
    repeat (n) @(negedge clock_in);
  endtask

  // Field area assumes a pattern count of three
  function srw_upd_e kind(input logic [11:0] a);
    if (a <= 12'h003 || a == 12'h017 || a == 12'h028) return UPD_IMMEDIATE;
    if (a <= 12'h072) return UPD_VSYNC;
    if (a >= 12'h800) return a < 12'h830 ? UPD_SAMPLE : UPD_VSYNC;
    return UPD_NONE;
  endfunction

  task burst(input logic [11:0] a, input int n);
    int k;
    k = 0;
    for (int i = 0; i < n; i++) begin
      notes.push_back({a + 12'(i), words[i], kind(a + 12'(i))});
    end
    addr_in = a;
    cnt_m1 = 5'(n - 1);
    data_in = words[0];
    start_in = 1;
    wait_cyc(1);
    start_in = 0;
    for (int c = 0; c < 1200 && busy === 1'b1; c++) begin
      if (take === 1'b1 && k < 3) begin
        k++;
        data_in = words[k];
      end
      wait_cyc(1);
    end
    check(busy === 1'b0, "host hung in burst");
    wait_cyc(10);
  endtask

  task raw(input logic [39:0] v, input int n);
    lnk2.serial_load_strobe = 0;
    for (int i = 0; i < n; i++) begin
      lnk2.serial_data = v[i];
      wait_cyc(2);
      lnk2.serial_clock = 1;
      wait_cyc(4);
      lnk2.serial_clock = 0;
      wait_cyc(2);
    end
    lnk2.serial_load_strobe = 1;
    lnk2.serial_data = ~lnk2.serial_data;
    wait_cyc(20);
  endtask

  // Pulse one input away from idle: 0 sample point, 1 vertical, 2 horizontal
  task pulse(input int sel);
    for (int p = 0; p < 2; p++) begin
      case (sel)
        0: pix = ~pix;
        1: vsync = ~vsync;
        default: hsync = ~hsync;
      endcase
      wait_cyc(p == 0 ? 5 : 10);
    end
  endtask

  always @(posedge clock_in) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      tally_and_finish();
    end
    if (!rst_in && wv === 1'b1) begin
      if (notes.size() == 0) begin
        check(1'b0, "write not requested");
      end else begin
        check({wa, wd, wt} === notes[0], "committed write differs");
        void'(notes.pop_front());
      end
    end
    n_va += int'(va === 1'b1);
    n_fa += int'(fa === 1'b1);
    n_pa += int'(pa === 1'b1);
    if (!rst_in && wv2 === 1'b1) begin
      n2++;
      got_a2 = wa2;
      got_d2 = wd2;
    end
  end

  initial begin
    void'($urandom(32'hee57));
    lnk2.serial_clock = 0;
    lnk2.serial_data = 0;
    lnk2.serial_load_strobe = 1;
    wait_cyc(3);
    rst_in = 0;
    wait_cyc(6);
    for (int i = 0; i < 4; i++) words[i] = 28'($urandom());
    words[0] = 28'h2;
    burst(12'h017, 1);
    check(uline === 28'h2, "update line");
    words[0] = 28'h3;
    burst(12'h028, 3);
    check(hcnt === 28'h3 && fbase === 12'h830, "field base");
    burst(12'h805, 2);
    burst(12'h830, 1);
    burst(12'h073, 1);
    check(aerr === 1'b1, "undefined address flag");
    burst(12'h004, 1);
    check(aerr === 1'b0 && n_va == 0, "applied before sync");
    grp = 1;
    pulse(0);
    check(n_pa == 0, "pattern applied while unused");
    grp = 0;
    pulse(0);
    check(n_pa == 1 && pgrp === 5'h0, "pattern apply");
    pulse(1);
    check(n_fa == 1 && n_va == 0, "field apply at sync");
    pulse(2);
    check(n_va == 0, "sync apply too early");
    pulse(2);
    check(n_va == 1, "sync apply at chosen line");
    raw({words[1], 12'h002}, 22);
    raw({words[2], 12'h001}, 40);
    check(n2 == 1 && {got_a2, got_d2} === {12'h1, words[2]}, "short");
    tally_and_finish();
  end
endmodule
